// file: rtl/cacc_pkg.sv
package cacc_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_MODE    = 4'h1;
   localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
   localparam logic [3:0] ADDR_CNT_HI  = 4'h3;
   localparam logic [3:0] ADDR_MMODE   = 4'h4;
   localparam logic [3:0] ADDR_CAP_LO  = 4'h5;
   localparam logic [3:0] ADDR_CAP_HI  = 4'h6;
   localparam logic [3:0] ADDR_STATUS  = 4'h7;

   // Counter control register fields
   localparam int CTRL_OVF_BIT = 7;
   localparam int CTRL_RUN_BIT = 6;
   localparam int CTRL_EVT_BIT = 4;

   // Counter mode register fields
   localparam int MODE_IDLE_BIT = 7;
   localparam int MODE_WDT_BIT  = 6;
   localparam int MODE_SRC_HI   = 2;
   localparam int MODE_SRC_LO   = 1;
   localparam int MODE_OVFIE_BIT = 0;

   // Module mode register fields
   localparam int MM_CMP_BIT  = 6;
   localparam int MM_RISE_BIT = 5;
   localparam int MM_FALL_BIT = 4;
   localparam int MM_MAT_BIT  = 3;
   localparam int MM_TOG_BIT  = 2;
   localparam int MM_PWM_BIT  = 1;
   localparam int MM_IE_BIT   = 0;

   // Reset values
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] MODE_RST  = 8'h00;
   localparam logic [7:0] MMODE_RST = 8'h00;
   localparam logic [7:0] BYTE_RST  = 8'h00;

   // Oscillator prescale counts
   localparam int DIV12_COUNT = 12;
   localparam int DIV4_COUNT  = 4;

   // Count source selection
   localparam logic [1:0] SRC_DIV12 = 2'h0;
   localparam logic [1:0] SRC_DIV4  = 2'h1;
   localparam logic [1:0] SRC_TMR0  = 2'h2;
   localparam logic [1:0] SRC_EXT   = 2'h3;

   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } cacc_req_t;

   // Module mode decode
   typedef enum logic [1:0] {
      CACC_MD_OFF,
      CACC_MD_CAPTURE,
      CACC_MD_COMPARE,
      CACC_MD_PWM
   } cacc_mode_t;

endpackage

// file: rtl/cacc_top.sv
// Functional notes
// - Source select picks osc/12, osc/4, timer 0 overflow or external count input.
// - Idle-halt bit stops the counter while the processor idles.
// - Watchdog-enable bit in the counter mode register is kept and exported.
// - Overflow sets the flag; interrupt only with overflow interrupt enable.
// - Counter advances only while the run bit, control bit 6, is set.
// - Overflow flag, control bit 7, set by hardware, cleared only by software.
// - Module event flag, control bit 4, set on match or capture; software clears.
// - Module interrupt when event flag and module interrupt enable are set.
// - Module mode bit 1 selects PWM; needs compare enable too.
// - Toggle bit inverts the module pin on every counter match.
// - Match bit sets the event flag on every counter match.
// - Bit 4 captures falling edges, bit 5 rising, both for any edge.
// - Module mode bit 6 enables the compare function.
// - On an enabled pin edge copy the 16-bit counter into the capture registers.
// - Compare enable plus match gives a software timer with flag and interrupt.
// - Toggle, match and compare enable together give high-speed output.
// - PWM output low while counter low byte below duty low, else high.
// - In PWM the duty low reloads from duty high on low byte FF to 00.
// - Comparator output may serve as the capture trigger.
`timescale 1ns/1ps
`default_nettype none

module cacc_top (
   // Clock, reset, enable
   input  wire logic       MCLK_I,
   input  wire logic       RSTN_I,
   input  wire logic       CE_I,
   // Register port
   input  wire logic [3:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   // System context
   input  wire logic       IDLE_I,
   input  wire logic       TMR0_OVF_I,
   input  wire logic       CMP_OUT_I,
   input  wire logic       CAP_SEL_CMP_I,
   // External pins
   input  wire logic       EXT_COUNT_I,
   input  wire logic       MODULE_IO_PIN_I,
   output logic            MODULE_IO_PIN_O,
   output logic            MODULE_IO_PIN_OE_N_O,
   // Interrupt requests and watchdog enable
   output logic            OVF_IRQ_O,
   output logic            MOD_IRQ_O,
   output logic            WDT_EN_O
);

   cacc_pkg::cacc_req_t  req;
   cacc_pkg::cacc_mode_t mode;

   logic [7:0]  ctrl_q;
   logic [7:0]  cmode_q;
   logic [7:0]  mmode_q;
   logic [15:0] cnt_q;
   logic [7:0]  cap_lo_q;
   logic [7:0]  cap_hi_q;
   logic [3:0]  pre_q;
   logic        tmr0_q;
   logic [2:0]  ext_sync_q;
   logic [2:0]  pin_sync_q;
   logic [2:0]  cmp_sync_q;
   logic        pin_out_q;
   logic        tick;
   logic        step;
   logic        ovf;
   logic        trig_now;
   logic        trig_prev;
   logic        rise;
   logic        fall;
   logic        cap_evt;
   logic        match;
   logic        match_evt;
   logic        pwm_on;
   logic        wr_ctrl;

   assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};
   assign wr_ctrl = req.wr && (req.addr == cacc_pkg::ADDR_CTRL);

   // Mode decode from the module mode register
   always_comb begin
      mode = cacc_pkg::CACC_MD_OFF;
      if (mmode_q[cacc_pkg::MM_PWM_BIT] && mmode_q[cacc_pkg::MM_CMP_BIT]) begin
         mode = cacc_pkg::CACC_MD_PWM;
      end else if (mmode_q[cacc_pkg::MM_RISE_BIT] || mmode_q[cacc_pkg::MM_FALL_BIT]) begin
         mode = cacc_pkg::CACC_MD_CAPTURE;
      end else if (mmode_q[cacc_pkg::MM_CMP_BIT]) begin
         mode = cacc_pkg::CACC_MD_COMPARE;
      end
   end

   // Pin and count input synchronisers; stage 0 is read only by stage 1
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         ext_sync_q <= 3'h0;
         pin_sync_q <= 3'h0;
         cmp_sync_q <= 3'h0;
         tmr0_q     <= 1'b0;
      end else if (CE_I) begin
         ext_sync_q <= {ext_sync_q[1:0], EXT_COUNT_I};
         pin_sync_q <= {pin_sync_q[1:0], MODULE_IO_PIN_I};
         cmp_sync_q <= {cmp_sync_q[1:0], CMP_OUT_I};
         tmr0_q     <= TMR0_OVF_I;
      end
   end

   // Oscillator prescaler, free running so divided ticks stay evenly spaced
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         pre_q <= 4'h0;
      end else if (CE_I) begin
         if (pre_q == 4'(cacc_pkg::DIV12_COUNT - 1)) begin
            pre_q <= 4'h0;
         end else begin
            pre_q <= pre_q + 4'h1;
         end
      end
   end

   // Source tick selection
   always_comb begin
      case (cmode_q[cacc_pkg::MODE_SRC_HI:cacc_pkg::MODE_SRC_LO])
         cacc_pkg::SRC_DIV12: tick = (pre_q == 4'(cacc_pkg::DIV12_COUNT - 1));
         cacc_pkg::SRC_DIV4:  tick = (pre_q[1:0] == 2'(cacc_pkg::DIV4_COUNT - 1));
         cacc_pkg::SRC_TMR0:  tick = tmr0_q;
         cacc_pkg::SRC_EXT:   tick = ext_sync_q[1] && !ext_sync_q[2];
         default:             tick = 1'b0;
      endcase
   end

   // Run and idle gating
   assign step = tick && ctrl_q[cacc_pkg::CTRL_RUN_BIT]
                 && !(cmode_q[cacc_pkg::MODE_IDLE_BIT] && IDLE_I);
   assign ovf  = step && (cnt_q == 16'hFFFF);

   // Capture trigger: pin or comparator
   assign trig_now  = CAP_SEL_CMP_I ? cmp_sync_q[1] : pin_sync_q[1];
   assign trig_prev = CAP_SEL_CMP_I ? cmp_sync_q[2] : pin_sync_q[2];
   assign rise      = trig_now && !trig_prev;
   assign fall      = !trig_now && trig_prev;
   assign cap_evt   = (mode == cacc_pkg::CACC_MD_CAPTURE)
                      && ((rise && mmode_q[cacc_pkg::MM_RISE_BIT])
                      || (fall && mmode_q[cacc_pkg::MM_FALL_BIT]));

   // Match is taken once, on the step that lands on the compare value
   assign match     = (mode == cacc_pkg::CACC_MD_COMPARE) && step
                      && ((cnt_q + 16'h1) == {cap_hi_q, cap_lo_q});
   assign match_evt = match && mmode_q[cacc_pkg::MM_MAT_BIT];
   assign pwm_on    = (mode == cacc_pkg::CACC_MD_PWM);

   // Counter, writable bytes, one step per tick
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         cnt_q <= 16'h0000;
      end else if (CE_I) begin
         if (req.wr && req.addr == cacc_pkg::ADDR_CNT_LO) begin
            cnt_q[7:0] <= req.wdata;
         end else if (req.wr && req.addr == cacc_pkg::ADDR_CNT_HI) begin
            cnt_q[15:8] <= req.wdata;
         end else if (step) begin
            cnt_q <= cnt_q + 16'h1;
         end
      end
   end

   // Control register: flags set by hardware win over a software clear
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         ctrl_q <= cacc_pkg::CTRL_RST;
      end else if (CE_I) begin
         if (wr_ctrl) begin
            ctrl_q[cacc_pkg::CTRL_RUN_BIT] <= req.wdata[cacc_pkg::CTRL_RUN_BIT];
            ctrl_q[cacc_pkg::CTRL_OVF_BIT] <= req.wdata[cacc_pkg::CTRL_OVF_BIT]
                                              & ctrl_q[cacc_pkg::CTRL_OVF_BIT];
            ctrl_q[cacc_pkg::CTRL_EVT_BIT] <= req.wdata[cacc_pkg::CTRL_EVT_BIT]
                                              & ctrl_q[cacc_pkg::CTRL_EVT_BIT];
         end
         if (ovf) begin
            ctrl_q[cacc_pkg::CTRL_OVF_BIT] <= 1'b1;
         end
         if (cap_evt || match_evt) begin
            ctrl_q[cacc_pkg::CTRL_EVT_BIT] <= 1'b1;
         end
      end
   end

   // Mode registers
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         cmode_q <= cacc_pkg::MODE_RST;
         mmode_q <= cacc_pkg::MMODE_RST;
      end else if (CE_I) begin
         if (req.wr && req.addr == cacc_pkg::ADDR_MODE) begin
            cmode_q <= req.wdata & 8'hC7;
         end
         if (req.wr && req.addr == cacc_pkg::ADDR_MMODE) begin
            mmode_q <= req.wdata & 8'h7F;
         end
      end
   end

   // Capture and duty registers; a capture beats a same-cycle write
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         cap_lo_q <= cacc_pkg::BYTE_RST;
         cap_hi_q <= cacc_pkg::BYTE_RST;
      end else if (CE_I) begin
         if (cap_evt) begin
            cap_lo_q <= cnt_q[7:0];
            cap_hi_q <= cnt_q[15:8];
         end else begin
            if (req.wr && req.addr == cacc_pkg::ADDR_CAP_HI) begin
               cap_hi_q <= req.wdata;
            end
            if (pwm_on && step && cnt_q[7:0] == 8'hFF) begin
               cap_lo_q <= cap_hi_q;
            end else if (req.wr && req.addr == cacc_pkg::ADDR_CAP_LO) begin
               cap_lo_q <= req.wdata;
            end
         end
      end
   end

   // Module output pin
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         pin_out_q <= 1'b1;
      end else if (CE_I) begin
         if (pwm_on) begin
            pin_out_q <= (cnt_q[7:0] >= cap_lo_q);
         end else if (match && mmode_q[cacc_pkg::MM_TOG_BIT]) begin
            pin_out_q <= !pin_out_q;
         end
      end
   end

   // Outputs, all registered
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         MODULE_IO_PIN_O      <= 1'b1;
         MODULE_IO_PIN_OE_N_O <= 1'b1;
         OVF_IRQ_O            <= 1'b0;
         MOD_IRQ_O            <= 1'b0;
         WDT_EN_O             <= 1'b0;
      end else if (CE_I) begin
         MODULE_IO_PIN_O      <= pin_out_q;
         // Driven only in PWM or toggling; in capture the pin stays an input
         MODULE_IO_PIN_OE_N_O <= !(pwm_on || (mode == cacc_pkg::CACC_MD_COMPARE
                                  && mmode_q[cacc_pkg::MM_TOG_BIT]));
         OVF_IRQ_O            <= ctrl_q[cacc_pkg::CTRL_OVF_BIT]
                                 && cmode_q[cacc_pkg::MODE_OVFIE_BIT];
         MOD_IRQ_O            <= ctrl_q[cacc_pkg::CTRL_EVT_BIT]
                                 && mmode_q[cacc_pkg::MM_IE_BIT];
         WDT_EN_O             <= cmode_q[cacc_pkg::MODE_WDT_BIT];
      end
   end

   // Read data in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         RDATA_O <= 8'h00;
      end else if (CE_I) begin
         RDATA_O <= 8'h00;
         if (req.rd) begin
            case (req.addr)
               cacc_pkg::ADDR_CTRL:   RDATA_O <= ctrl_q & 8'hD0;
               cacc_pkg::ADDR_MODE:   RDATA_O <= cmode_q;
               cacc_pkg::ADDR_CNT_LO: RDATA_O <= cnt_q[7:0];
               cacc_pkg::ADDR_CNT_HI: RDATA_O <= cnt_q[15:8];
               cacc_pkg::ADDR_MMODE:  RDATA_O <= mmode_q;
               cacc_pkg::ADDR_CAP_LO: RDATA_O <= cap_lo_q;
               cacc_pkg::ADDR_CAP_HI: RDATA_O <= cap_hi_q;
               cacc_pkg::ADDR_STATUS: RDATA_O <= {6'h00, 1'(mode), pin_out_q};
               default:               RDATA_O <= 8'h00;
            endcase
         end
      end
   end

   // Assertions
   property p_ovf_set;
      @(posedge MCLK_I) disable iff (!RSTN_I) (CE_I && ovf) |=> ctrl_q[cacc_pkg::CTRL_OVF_BIT];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

   property p_ovf_sticky;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (ctrl_q[cacc_pkg::CTRL_OVF_BIT] && !(CE_I && wr_ctrl)) |=> ctrl_q[cacc_pkg::CTRL_OVF_BIT];
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

   property p_evt_sticky;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (ctrl_q[cacc_pkg::CTRL_EVT_BIT] && !(CE_I && wr_ctrl)) |=> ctrl_q[cacc_pkg::CTRL_EVT_BIT];
   endproperty
   a_evt_sticky: assert property (p_evt_sticky) else $error("event flag lost");

   property p_stopped;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (!ctrl_q[cacc_pkg::CTRL_RUN_BIT] && !req.wr) |=> $stable(cnt_q);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

   property p_idle;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (IDLE_I && cmode_q[cacc_pkg::MODE_IDLE_BIT] && !req.wr) |=> $stable(cnt_q);
   endproperty
   a_idle: assert property (p_idle) else $error("counter moved in idle");

   property p_capture;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && cap_evt) |=> ({cap_hi_q, cap_lo_q} == $past(cnt_q)) && ctrl_q[cacc_pkg::CTRL_EVT_BIT];
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_toggle;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && match && mmode_q[cacc_pkg::MM_TOG_BIT] && !pwm_on) |=> (pin_out_q != $past(pin_out_q));
   endproperty
   a_toggle: assert property (p_toggle) else $error("pin did not toggle");

   property p_mod_irq;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && ctrl_q[cacc_pkg::CTRL_EVT_BIT] && mmode_q[cacc_pkg::MM_IE_BIT]) |=> MOD_IRQ_O;
   endproperty
   a_mod_irq: assert property (p_mod_irq) else $error("module irq missing");

   property p_pwm;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && pwm_on) |=> (pin_out_q == ($past(cnt_q[7:0]) >= $past(cap_lo_q)));
   endproperty
   a_pwm: assert property (p_pwm) else $error("pwm level wrong");

   property p_wdt_follow;
      @(posedge MCLK_I) disable iff (!RSTN_I) CE_I |=> (WDT_EN_O == $past(cmode_q[cacc_pkg::MODE_WDT_BIT]));
   endproperty
   a_wdt_follow: assert property (p_wdt_follow) else $error("watchdog enable not exported");

   property p_step_inc;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && step && !req.wr) |=> (cnt_q == $past(cnt_q) + 16'h1);
   endproperty
   a_step_inc: assert property (p_step_inc) else $error("counter did not step once");

   property p_ovf_irq;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && ctrl_q[cacc_pkg::CTRL_OVF_BIT] && cmode_q[cacc_pkg::MODE_OVFIE_BIT]) |=> OVF_IRQ_O;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

   property p_match_flag;
      @(posedge MCLK_I) disable iff (!RSTN_I) (CE_I && match_evt) |=> ctrl_q[cacc_pkg::CTRL_EVT_BIT];
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match did not set event flag");

   property p_pwm_reload;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         (CE_I && pwm_on && step && (cnt_q[7:0] == 8'hFF)) |=> (cap_lo_q == $past(cap_hi_q));
   endproperty
   a_pwm_reload: assert property (p_pwm_reload) else $error("duty low not reloaded");

   property p_pwm_drive;
      @(posedge MCLK_I) disable iff (!RSTN_I) (CE_I && pwm_on) |=> !MODULE_IO_PIN_OE_N_O;
   endproperty
   a_pwm_drive: assert property (p_pwm_drive) else $error("pwm pin not driven");

   // Enabled edge of the chosen trigger, then flag and interrupt a cycle apart
   sequence s_edge_enabled;
      CE_I && (mode == cacc_pkg::CACC_MD_CAPTURE)
      && ((rise && mmode_q[cacc_pkg::MM_RISE_BIT]) || (fall && mmode_q[cacc_pkg::MM_FALL_BIT]));
   endsequence

   sequence s_flag_irq;
      ctrl_q[cacc_pkg::CTRL_EVT_BIT] ##1 MOD_IRQ_O;
   endsequence

   property p_edge_irq;
      @(posedge MCLK_I) disable iff (!RSTN_I)
         s_edge_enabled ##0 (mmode_q[cacc_pkg::MM_IE_BIT] && !req.wr) |=> s_flag_irq;
   endproperty
   a_edge_irq: assert property (p_edge_irq) else $error("capture edge gave no flag or irq");

endmodule

`default_nettype wire

// file: tb/cacc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far side of the block: count input source and the module pin when released
module cacc_pin_model (
   // Clock and design pin side
   input  wire logic clk_i,
   input  wire logic pin_o_i,
   input  wire logic oe_n_i,
   // Lines driven by the far side
   output logic      ext_cnt_o,
   output logic      pin_i_o
);
   logic drv_q = 1'b0;

   initial ext_cnt_o = 1'b0;

   // Wire level: the design wins while its enable is low
   assign pin_i_o = oe_n_i ? drv_q : pin_o_i;

   // Level is held long enough to pass the two-stage synchroniser
   task automatic set_pin(input logic v);
      drv_q <= v;
      repeat (6) @(posedge clk_i);
   endtask

   // Count pulses; the line idles low between them
   task automatic pulse_ext(input int n);
      repeat (n) begin
         ext_cnt_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         ext_cnt_o <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask
endmodule

`default_nettype wire

// file: tb/cacc_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module cacc_top_test;
   logic        mclk, rstn, wr, rd, idle, tmr0, cmp_out, cap_sel, rd_pend, en, ce;
   logic        ext_cnt, pin_i, pin_o, oe_n, ovf_irq, mod_irq, wdt_en;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [15:0] rnd, note;
   logic [15:0] exp_q[$];
   logic [7:0]  mm [3] = '{8'h21, 8'h11, 8'h31};
   int          error_cnt, checks;

   cacc_top dut_u (.MCLK_I(mclk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IDLE_I(idle), .TMR0_OVF_I(tmr0), .CMP_OUT_I(cmp_out),
      .CAP_SEL_CMP_I(cap_sel), .EXT_COUNT_I(ext_cnt), .MODULE_IO_PIN_I(pin_i), .MODULE_IO_PIN_O(pin_o),
      .MODULE_IO_PIN_OE_N_O(oe_n), .OVF_IRQ_O(ovf_irq), .MOD_IRQ_O(mod_irq), .WDT_EN_O(wdt_en));

   cacc_pin_model pin_u (.clk_i(mclk), .pin_o_i(pin_o), .oe_n_i(oe_n), .ext_cnt_o(ext_cnt), .pin_i_o(pin_i));

   // Clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] expv);
      checks++;
      if (seen !== expv) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Register port cycles; the idle cycle at the end keeps strobes from being set twice in one step
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back({m, e & m});
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic set_cnt(input logic [15:0] v);
      wr_reg(cacc_pkg::ADDR_CNT_LO, v[7:0]);
      wr_reg(cacc_pkg::ADDR_CNT_HI, v[15:8]);
   endtask

   // Timer 0 overflow pulses, then time for the flags to land
   task automatic tick(input int n);
      repeat (n) begin
         tmr0 <= 1'b1;
         @(posedge mclk);
         tmr0 <= 1'b0;
         @(posedge mclk);
      end
      repeat (3) @(posedge mclk);
   endtask

   // Port checks happen off the edge so registered outputs have settled
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // Read data stand only in the cycle after the strobe; pair them with the oldest note
   always @(posedge mclk) begin
      if (rd_pend) begin
         note = exp_q.pop_front();
         check("RDATA_O", rdata & note[15:8], note[7:0]);
      end
      rd_pend <= rd;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      close_out();
   end

   initial begin
      {rstn, wr, rd, idle, tmr0, cmp_out, cap_sel} = 7'h00;
      ce = 1'b1;
      addr = 4'h0;
      wdata = 8'h00;
      error_cnt = 0;
      checks = 0;
      void'($urandom(64));
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h01);
      check("MODULE_IO_PIN_OE_N_O", {7'h00, oe_n}, 8'h01);
      for (int a = 0; a < 7; a++) rd_reg(a[3:0], cacc_pkg::BYTE_RST, 8'hFF);
      rd_reg(cacc_pkg::ADDR_STATUS, 8'h01, 8'hFF);
      rd_reg(4'hC, 8'h00, 8'hFF);
      wr_reg(cacc_pkg::ADDR_MODE, 8'h40);
      settle();
      check("WDT_EN_O", {7'h00, wdt_en}, 8'h01);
      // Each count source; prescaled sources land within a small window
      for (int s = 0; s < 4; s++) begin
         wr_reg(cacc_pkg::ADDR_CTRL, 8'h00);
         set_cnt(16'h0000);
         wr_reg(cacc_pkg::ADDR_MODE, {5'h00, s[1:0], 1'b0});
         wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
         case (s)
            0: repeat (120) @(posedge mclk);
            1: repeat (40) @(posedge mclk);
            2: tick(6);
            default: pin_u.pulse_ext(6);
         endcase
         wr_reg(cacc_pkg::ADDR_CTRL, 8'h00);
         if (s < 2)
            rd_reg(cacc_pkg::ADDR_CNT_LO, 8'h08, 8'hFC);
         else
            rd_reg(cacc_pkg::ADDR_CNT_LO, 8'h06, 8'hFF);
      end
      pin_u.pulse_ext(3);
      rd_reg(cacc_pkg::ADDR_CNT_LO, 8'h06, 8'hFF);
      // Idle halt
      wr_reg(cacc_pkg::ADDR_MODE, 8'h84);
      set_cnt(16'h0000);
      idle <= 1'b1;
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      tick(4);
      rd_reg(cacc_pkg::ADDR_CNT_LO, 8'h00, 8'hFF);
      idle <= 1'b0;
      tick(4);
      rd_reg(cacc_pkg::ADDR_CNT_LO, 8'h04, 8'hFF);
      // Clock enable low freezes the counter although source ticks arrive
      ce <= 1'b0;
      tick(3);
      ce <= 1'b1;
      rd_reg(cacc_pkg::ADDR_CNT_LO, 8'h04, 8'hFF);
      // Overflow flag and its interrupt gate
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h00);
      set_cnt(16'hFFFF);
      wr_reg(cacc_pkg::ADDR_MODE, 8'h05);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      tick(1);
      settle();
      check("OVF_IRQ_O", {7'h00, ovf_irq}, 8'h01);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'hC0, 8'hC0);
      rd_reg(cacc_pkg::ADDR_CNT_HI, 8'h00, 8'hFF);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h40, 8'hC0);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'hC0);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h40, 8'hC0);
      settle();
      check("OVF_IRQ_O", {7'h00, ovf_irq}, 8'h00);
      wr_reg(cacc_pkg::ADDR_MODE, 8'h04);
      set_cnt(16'hFFFF);
      tick(1);
      settle();
      check("OVF_IRQ_O", {7'h00, ovf_irq}, 8'h00);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h80, 8'h80);
      // Capture on each edge selection, rising then falling
      for (int m = 0; m < 3; m++) begin
         for (int v = 1; v >= 0; v--) begin
            wr_reg(cacc_pkg::ADDR_CTRL, 8'h00);
            wr_reg(cacc_pkg::ADDR_MMODE, mm[m]);
            rnd = 16'($urandom);
            set_cnt(rnd);
            pin_u.set_pin(v[0]);
            en = mm[m][v ? 5 : 4];
            if (en) begin
               rd_reg(cacc_pkg::ADDR_CAP_LO, rnd[7:0], 8'hFF);
               rd_reg(cacc_pkg::ADDR_CAP_HI, rnd[15:8], 8'hFF);
            end
            rd_reg(cacc_pkg::ADDR_CTRL, {3'h0, en, 4'h0}, 8'h10);
            settle();
            check("MOD_IRQ_O", {7'h00, mod_irq}, {7'h00, en});
         end
      end
      // Comparator as capture trigger
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h00);
      cap_sel <= 1'b1;
      wr_reg(cacc_pkg::ADDR_MMODE, 8'h21);
      rnd = 16'($urandom);
      set_cnt(rnd);
      cmp_out <= 1'b1;
      repeat (6) @(posedge mclk);
      rd_reg(cacc_pkg::ADDR_CAP_LO, rnd[7:0], 8'hFF);
      rd_reg(cacc_pkg::ADDR_CAP_HI, rnd[15:8], 8'hFF);
      cap_sel <= 1'b0;
      // High-speed output: match at 5
      wr_reg(cacc_pkg::ADDR_MMODE, 8'h4D);
      wr_reg(cacc_pkg::ADDR_CAP_LO, 8'h05);
      wr_reg(cacc_pkg::ADDR_CAP_HI, 8'h00);
      set_cnt(16'h0000);
      wr_reg(cacc_pkg::ADDR_MODE, 8'h04);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      tick(4);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h40, 8'h50);
      settle();
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h01);
      tick(1);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h50, 8'h50);
      settle();
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h00);
      check("MODULE_IO_PIN_OE_N_O", {7'h00, oe_n}, 8'h00);
      check("MOD_IRQ_O", {7'h00, mod_irq}, 8'h01);
      // Software timer without toggle or interrupt, then match without compare enable
      wr_reg(cacc_pkg::ADDR_MMODE, 8'h48);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      set_cnt(16'h0004);
      tick(1);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h50, 8'h50);
      settle();
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h00);
      check("MOD_IRQ_O", {7'h00, mod_irq}, 8'h00);
      wr_reg(cacc_pkg::ADDR_MMODE, 8'h08);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      set_cnt(16'h0004);
      tick(1);
      rd_reg(cacc_pkg::ADDR_CTRL, 8'h40, 8'h50);
      // PWM threshold and glitch-free reload
      wr_reg(cacc_pkg::ADDR_MMODE, 8'h42);
      wr_reg(cacc_pkg::ADDR_CAP_LO, 8'h80);
      wr_reg(cacc_pkg::ADDR_CAP_HI, 8'h40);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h00);
      set_cnt(16'h007F);
      settle();
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h00);
      check("MODULE_IO_PIN_OE_N_O", {7'h00, oe_n}, 8'h00);
      wr_reg(cacc_pkg::ADDR_CNT_LO, 8'h80);
      settle();
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h01);
      wr_reg(cacc_pkg::ADDR_CNT_LO, 8'hFF);
      wr_reg(cacc_pkg::ADDR_CTRL, 8'h40);
      tick(1);
      rd_reg(cacc_pkg::ADDR_CAP_LO, 8'h40, 8'hFF);
      rd_reg(cacc_pkg::ADDR_STATUS, 8'h02, 8'hFF);
      settle();
      check("MODULE_IO_PIN_O", {7'h00, pin_o}, 8'h00);
      wr_reg(cacc_pkg::ADDR_MMODE, 8'h02);
      settle();
      check("MODULE_IO_PIN_OE_N_O", {7'h00, oe_n}, 8'h01);
      close_out();
   end
endmodule

`default_nettype wire
